//--- hdl/ftp_chan.sv
// one fan channel: counts timebase ticks across two tach periods
`timescale 1ns/1ps
`default_nettype none
module ftp_chan
    import ftp_pkg::*;
(
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    // timebase and filtered tach edge
    input  wire logic             tb_tick,
    input  wire logic             tach_rise,
    // requested acquisition mode
    input  wire logic [1:0]       acq_mode,
    // result
    output logic      [CNT_W-1:0] period_count,
    output logic      [1:0]       acq_state,
    output logic                  meas_done
);
    typedef enum logic {FTP_WAIT_FIRST, FTP_MEASURE} ftp_meas_e;

    ftp_meas_e        st_r, st_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic [1:0]       edges_r, edges_nxt;
    logic [CNT_W-1:0] res_r, res_nxt;
    logic [1:0]       acq_r, acq_nxt;
    logic             done_nxt;
    logic             done_r;
    logic             cnt_sat;
    logic [CNT_W-1:0] meas_val;
    logic [CNT_W:0]   avg_sum;
    logic [1:0]       mode_eff;

    assign cnt_sat  = cnt_r == CNT_MAX;
    // a tick landing on the closing edge still belongs to this measurement
    assign meas_val = (tb_tick && !cnt_sat) ? cnt_r + 14'h0001 : cnt_r;
    assign avg_sum  = {1'b0, meas_val} + {1'b0, res_r};
    assign mode_eff = (acq_mode == ACQ_RESERVED) ? ACQ_NORMAL : acq_mode;

    always_comb begin
        st_nxt    = st_r;
        cnt_nxt   = cnt_r;
        edges_nxt = edges_r;
        res_nxt   = res_r;
        acq_nxt   = acq_r;
        done_nxt  = 1'b0;
        unique case (st_r)
            FTP_WAIT_FIRST: begin
                if (tach_rise) begin
                    st_nxt    = FTP_MEASURE;
                    cnt_nxt   = CNT_RESET;
                    edges_nxt = 2'h0;
                    if (cnt_r > WAIT_LATE) begin
                        // late first edge: refresh now, nothing valid yet
                        res_nxt  = CNT_MAX;
                        acq_nxt  = mode_eff;
                        done_nxt = 1'b1;
                    end
                end else if (tb_tick) begin
                    if (cnt_sat) begin
                        // no edge at all: stalled or unconnected
                        res_nxt  = CNT_MAX;
                        acq_nxt  = mode_eff;
                        done_nxt = 1'b1;
                        cnt_nxt  = CNT_RESET;
                    end else begin
                        cnt_nxt = cnt_r + 14'h0001;
                    end
                end
            end
            FTP_MEASURE: begin
                if (tach_rise) begin
                    if (edges_r == PERIODS_LAST) begin
                        // closing edge opens the next window: back to back
                        // a cleared or stalled previous result is no basis for averaging
                        if (mode_eff == ACQ_ADAPT1 && res_r != CNT_MAX &&
                            res_r != CNT_RESET) begin
                            res_nxt = avg_sum[CNT_W:1];
                        end else begin
                            res_nxt = meas_val;
                        end
                        acq_nxt   = mode_eff;
                        done_nxt  = 1'b1;
                        cnt_nxt   = CNT_RESET;
                        edges_nxt = 2'h0;
                    end else begin
                        edges_nxt = edges_r + 2'h1;
                        cnt_nxt   = meas_val;
                    end
                end else if (tb_tick) begin
                    if (cnt_sat) begin
                        res_nxt  = CNT_MAX;
                        acq_nxt  = mode_eff;
                        done_nxt = 1'b1;
                        cnt_nxt  = CNT_RESET;
                        st_nxt   = FTP_WAIT_FIRST;
                    end else begin
                        cnt_nxt = cnt_r + 14'h0001;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r    <= FTP_WAIT_FIRST;
            cnt_r   <= CNT_RESET;
            edges_r <= 2'h0;
            res_r   <= CNT_RESET;
            acq_r   <= ACQ_RESET;
            done_r  <= 1'b0;
        end else begin
            st_r    <= st_nxt;
            cnt_r   <= cnt_nxt;
            edges_r <= edges_nxt;
            res_r   <= res_nxt;
            acq_r   <= acq_nxt;
            done_r  <= done_nxt;
        end
    end

    assign period_count = res_r;
    assign acq_state    = acq_r;
    assign meas_done    = done_r;
endmodule // ftp_chan
`default_nettype wire

//--- hdl/ftp_pkg.sv
// shared constants for the fan tachometer period measurement block
package ftp_pkg;
    localparam int          FAN_N        = 4;
    localparam int          CNT_W        = 14;
    localparam logic [13:0] CNT_MAX      = 14'h3fff;
    localparam logic [13:0] CNT_RESET    = 14'h0000;
    // timebase: fractional accumulator, adds TB_HZ per clock, wraps at CLK_HZ
    localparam int          CLK_HZ       = 20_000_000;
    localparam int          TB_HZ        = 22_500;
    localparam int          ACC_W        = 25;
    localparam logic [24:0] ACC_STEP     = 25'(TB_HZ);
    localparam logic [24:0] ACC_WRAP     = 25'(CLK_HZ);
    // tach input spike filter: least stable time before a level is accepted
    localparam int          FILT_NS      = 200;
    localparam int          CLK_NS       = 1_000_000_000 / CLK_HZ;
    localparam int          FILT_CYC     = (FILT_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [2:0]  FILT_LAST    = 3'(FILT_CYC - 1);
    // rising edges counted after the opening edge before the next one closes a measurement
    localparam logic [1:0]  PERIODS_LAST = 2'h1;
    // ticks spent waiting for a first edge beyond which a full window would
    // push the next stored result past one second
    localparam logic [13:0] WAIT_LATE    = 14'h1770;
    // register offsets
    localparam logic [7:0]  OFS_FAN1_LOW  = 8'h6e;
    localparam logic [7:0]  OFS_FAN1_HIGH = 8'h6f;
    localparam logic [7:0]  OFS_FAN2_LOW  = 8'h70;
    localparam logic [7:0]  OFS_FAN2_HIGH = 8'h71;
    localparam logic [7:0]  OFS_FAN3_LOW  = 8'h72;
    localparam logic [7:0]  OFS_FAN3_HIGH = 8'h73;
    localparam logic [7:0]  OFS_FAN4_LOW  = 8'h74;
    localparam logic [7:0]  OFS_FAN4_HIGH = 8'h75;
    localparam logic [7:0]  REG_RESET     = 8'h00;
    localparam logic [7:0]  RD_UNMAPPED   = 8'h00;
    // field positions
    localparam int          LOW_CNT_LSB  = 2;
    localparam int          HIGH_CNT_LSB = 6;
    // acquisition state codes
    localparam logic [1:0]  ACQ_NORMAL   = 2'b00;
    localparam logic [1:0]  ACQ_RESERVED = 2'b01;
    localparam logic [1:0]  ACQ_ADAPT1   = 2'b10;
    localparam logic [1:0]  ACQ_ADAPT2   = 2'b11;
    localparam logic [1:0]  ACQ_RESET    = 2'b00;
endpackage : ftp_pkg

//--- hdl/ftp_timebase.sv
// 22.5 kHz tick generator from the system clock
`timescale 1ns/1ps
`default_nettype none
module ftp_timebase
    import ftp_pkg::*;
(
    // clock and reset
    input  wire logic core_clk,
    input  wire logic rst_n,
    // tick out
    output logic      tb_tick
);
    logic [ACC_W-1:0] acc_r;
    logic [ACC_W-1:0] acc_nxt;
    logic [ACC_W-1:0] acc_sum;
    logic             wrap;

    // fractional step keeps the long-run rate exact; tick jitter is one clock
    assign acc_sum = acc_r + ACC_STEP;
    assign wrap    = acc_sum >= ACC_WRAP;
    assign acc_nxt = wrap ? acc_sum - ACC_WRAP : acc_sum;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_r   <= '0;
            tb_tick <= 1'b0;
        end else begin
            acc_r   <= acc_nxt;
            tb_tick <= wrap;
        end
    end
endmodule // ftp_timebase
`default_nettype wire

//--- hdl/ftp_top.sv
// fan tachometer period measurement: four channels and their read registers
`timescale 1ns/1ps
`default_nettype none
module ftp_top
    import ftp_pkg::*;
(
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    // tach pins, asynchronous
    input  wire logic [FAN_N-1:0] fan_tach,
    // per-fan acquisition mode, two bits per fan, fan 1 in bits 1:0
    input  wire logic [7:0]       fan_acq_mode,
    // register read port from the management interface
    input  wire logic             reg_rd_en,
    input  wire logic [7:0]       reg_addr,
    output logic      [7:0]       reg_rdata,
    output logic                  reg_rd_valid,
    output logic                  reg_hit,
    // status
    output logic      [FAN_N-1:0] fan_updated,
    output logic      [FAN_N-1:0] fan_stalled
);
    logic               tb_tick;
    logic [FAN_N-1:0]   tach_rise;
    logic [FAN_N-1:0]   chan_done;
    logic [CNT_W-1:0]   chan_cnt   [FAN_N];
    logic [1:0]         chan_acq   [FAN_N];
    logic [7:0]         low_byte   [FAN_N];
    logic [7:0]         high_byte  [FAN_N];

    ftp_timebase u_timebase (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .tb_tick  (tb_tick)
    );

    // per fan: synchroniser, spike filter, edge detect and measurement.
    // the tach pin is watched regardless of any drive state, so a fan that is
    // coasting or dead still gets a true count
    genvar g;
    generate
        for (g = 0; g < FAN_N; g = g + 1) begin : g_fan
            logic       sync1_r;
            logic       sync2_r;
            logic       filt_r;
            logic       filt_nxt;
            logic [2:0] stable_r;
            logic [2:0] stable_nxt;
            logic       filt_prev_r;
            logic       differs;

            // first stage is read only by the second
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    // idle pin sits high on its pull-up; matching it avoids a false rise
                    sync1_r <= 1'b1;
                    sync2_r <= 1'b1;
                end else begin
                    sync1_r <= fan_tach[g];
                    sync2_r <= sync1_r;
                end
            end

            // a new level is taken only after it has stood the filter time,
            // which keeps commutation spikes from closing a period early
            assign differs    = sync2_r != filt_r;
            assign stable_nxt = !differs ? 3'h0 :
                                (stable_r == FILT_LAST) ? 3'h0 : stable_r + 3'h1;
            assign filt_nxt   = (differs && stable_r == FILT_LAST) ? sync2_r : filt_r;

            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    stable_r    <= 3'h0;
                    filt_r      <= 1'b1;
                    filt_prev_r <= 1'b1;
                end else begin
                    stable_r    <= stable_nxt;
                    filt_r      <= filt_nxt;
                    filt_prev_r <= filt_r;
                end
            end

            assign tach_rise[g] = filt_r && !filt_prev_r;

            ftp_chan u_chan (
                .core_clk     (core_clk),
                .rst_n        (rst_n),
                .tb_tick      (tb_tick),
                .tach_rise    (tach_rise[g]),
                .acq_mode     (fan_acq_mode[2*g+1:2*g]),
                .period_count (chan_cnt[g]),
                .acq_state    (chan_acq[g]),
                .meas_done    (chan_done[g])
            );

            assign low_byte[g]  = {chan_cnt[g][LOW_CNT_LSB+3:0], chan_acq[g]};
            assign high_byte[g] = chan_cnt[g][CNT_W-1:HIGH_CNT_LSB];
            assign fan_stalled[g] = chan_cnt[g] == CNT_MAX;
        end
    endgenerate

    assign fan_updated = chan_done;

    // high-byte snapshot: reading a low byte freezes its high byte so the
    // pair stays coherent if a new measurement lands between the two reads;
    // a high read without a prior low read returns the live value
    logic [7:0]       snap_r     [FAN_N];
    logic [FAN_N-1:0] snap_vld_r;
    logic [FAN_N-1:0] snap_vld_nxt;
    logic [FAN_N-1:0] sel_low;
    logic [FAN_N-1:0] sel_high;
    logic [7:0]       rd_mux;
    logic             rd_hit;

    assign sel_low[0]  = reg_addr == OFS_FAN1_LOW;
    assign sel_low[1]  = reg_addr == OFS_FAN2_LOW;
    assign sel_low[2]  = reg_addr == OFS_FAN3_LOW;
    assign sel_low[3]  = reg_addr == OFS_FAN4_LOW;
    assign sel_high[0] = reg_addr == OFS_FAN1_HIGH;
    assign sel_high[1] = reg_addr == OFS_FAN2_HIGH;
    assign sel_high[2] = reg_addr == OFS_FAN3_HIGH;
    assign sel_high[3] = reg_addr == OFS_FAN4_HIGH;
    assign rd_hit      = |{sel_low, sel_high};

    always_comb begin
        rd_mux       = RD_UNMAPPED;
        snap_vld_nxt = snap_vld_r;
        for (int i = 0; i < FAN_N; i++) begin
            if (sel_low[i]) begin
                rd_mux = low_byte[i];
            end
            if (sel_high[i]) begin
                rd_mux = snap_vld_r[i] ? snap_r[i] : high_byte[i];
            end
            if (reg_rd_en && sel_low[i]) begin
                snap_vld_nxt[i] = 1'b1;
            end
            if (reg_rd_en && sel_high[i]) begin
                snap_vld_nxt[i] = 1'b0;
            end
        end
    end

    generate
        for (g = 0; g < FAN_N; g = g + 1) begin : g_snap
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    snap_r[g] <= REG_RESET;
                end else if (reg_rd_en && sel_low[g]) begin
                    snap_r[g] <= high_byte[g];
                end
            end
        end
    endgenerate

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            snap_vld_r   <= '0;
            reg_rdata    <= REG_RESET;
            reg_rd_valid <= 1'b0;
            reg_hit      <= 1'b0;
        end else begin
            snap_vld_r   <= snap_vld_nxt;
            reg_rd_valid <= reg_rd_en;
            if (reg_rd_en) begin
                reg_rdata <= rd_mux;
                reg_hit   <= rd_hit;
            end
        end
    end
endmodule // ftp_top
`default_nettype wire

//--- verification/fan_tach_period_measure_tb.sv
// self-checking bench for the fan tach period block
`timescale 1ns/1ps
`default_nettype none
module fan_tach_period_measure_tb
    import ftp_pkg::*;
;
    logic             core_clk;
    logic             rst_n;
    logic [FAN_N-1:0] fan_tach;
    logic [FAN_N-1:0] fan_run;
    logic [FAN_N-1:0] fan_updated;
    logic [FAN_N-1:0] fan_stalled;
    logic [7:0]       fan_acq_mode;
    logic [7:0]       reg_addr;
    logic [7:0]       reg_rdata;
    logic             reg_rd_en;
    logic             reg_rd_valid;
    logic             reg_hit;
    logic [63:0]      half_cyc;
    logic [31:0]      rng_r;
    int               errors;
    int               checks_done;
    int               upd_n [FAN_N] = '{default: 0};
    int               hv [FAN_N];

    ftp_top u_ftp_top (
        .core_clk(core_clk), .rst_n(rst_n), .fan_tach(fan_tach),
        .fan_acq_mode(fan_acq_mode), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
        .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid), .reg_hit(reg_hit),
        .fan_updated(fan_updated), .fan_stalled(fan_stalled));
    ftp_fan_model u_ftp_fan_model (
        .core_clk(core_clk), .rst_n(rst_n), .fan_run(fan_run),
        .half_cyc(half_cyc), .fan_tach(fan_tach));

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        for (int i = 0; i < FAN_N; i++) begin
            if (fan_updated[i] === 1'b1) upd_n[i] = upd_n[i] + 1;
        end
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // whole ticks in two periods; timebase phase may add one
    function automatic int exp_ticks(input int half);
        return (half * 4 * TB_HZ) / CLK_HZ;
    endfunction

    function automatic logic [1:0] exp_state(input logic [1:0] m);
        return (m == ACQ_RESERVED) ? ACQ_NORMAL : m;
    endfunction

    task automatic stop_test();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [13:0] exp, input logic [13:0] seen,
                         input bit slack);
        checks_done++;
        if (!(seen === exp || (slack && seen === exp + 14'h1))) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
        @(posedge core_clk);
        reg_rd_en <= 1'b1;
        reg_addr  <= a;
        @(posedge core_clk);
        reg_rd_en <= 1'b0;
        #1;
        check("read valid", 14'h1, {13'h0, reg_rd_valid}, 1'b0);
        d = reg_rdata;
        h = reg_hit;
    endtask

    // bounded wait until every fan has stored n results
    task automatic wait_upd(input int n);
        int t;
        t = 0;
        while ((upd_n[0] < n || upd_n[1] < n || upd_n[2] < n || upd_n[3] < n) && t < 80000) begin
            @(posedge core_clk);
            t++;
        end
        if (t >= 80000) begin
            errors++;
            $display("unexpected result wait: expected %0d seen %0d", n, upd_n[0]);
            stop_test();
        end
    endtask

    // both bytes of every fan against the expected window and mode
    task automatic check_fans(input logic [7:0] m);
        logic [7:0] d;
        logic [7:0] dh;
        logic       h;
        for (int i = 0; i < FAN_N; i++) begin
            rd(OFS_FAN1_LOW + 8'(2 * i), d, h);
            rd(OFS_FAN1_HIGH + 8'(2 * i), dh, h);
            check("period count", 14'(exp_ticks(hv[i])), {dh, d[7:2]}, 1'b1);
            check("acq state", {12'h0, exp_state(m[2*i +: 2])}, {12'h0, d[1:0]}, 1'b0);
            check("stall flag", 14'h0, {13'h0, fan_stalled[i]}, 1'b0);
        end
    endtask

    initial begin
        logic [7:0] d;
        logic [7:0] md;
        logic       h;
        rst_n        = 1'b0;
        reg_rd_en    = 1'b0;
        reg_addr     = 8'h00;
        fan_run      = 4'h0;
        half_cyc     = 64'h0;
        fan_acq_mode = 8'h00;
        errors       = 0;
        checks_done  = 0;
        rng_r        = 32'h619a;
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        // reset values, decode window and both neighbours
        for (int a = 8'h6d; a <= 8'h76; a++) begin
            rd(8'(a), d, h);
            check("reset data", 14'h0, {6'h0, d}, 1'b0);
            check("hit", {13'h0, 1'(a >= 8'h6e && a <= 8'h75)}, {13'h0, h}, 1'b0);
        end
        repeat (6) begin
            rng_r = xs(rng_r);
            rd(rng_r[7:0], d, h);
            check("random hit", {13'h0, rng_r[7:0] inside {[8'h6e:8'h75]}}, {13'h0, h}, 1'b0);
            check("random data", 14'h0, {6'h0, d}, 1'b0);
        end
        @(posedge core_clk);
        for (int i = 0; i < FAN_N; i++) begin
            rng_r = xs(rng_r);
            hv[i] = 1600 + int'(rng_r % 32'h640);
            half_cyc[16*i +: 16] <= 16'(hv[i]);
        end
        fan_run <= 4'hf;
        // normal mode first so the averaging mode starts from a good reading
        for (int ph = 0; ph < 2; ph++) begin
            md = ph ? {ACQ_ADAPT2, ACQ_ADAPT1, ACQ_RESERVED, ACQ_NORMAL} : 8'h00;
            @(posedge core_clk);
            fan_acq_mode <= md;
            wait_upd(2 * ph + 2);
            check_fans(md);
        end
        // mid-run reset with pins idle high, late restart: a false rise after
        // reset or averaging with the cleared count would skew the first result
        @(posedge core_clk);
        fan_run <= 4'h0;
        rst_n   <= 1'b0;
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(OFS_FAN3_LOW, d, h);
        check("reset data", 14'h0, {6'h0, d}, 1'b0);
        upd_n = '{default: 0};
        repeat (3000) @(posedge core_clk);
        fan_run <= 4'hf;
        wait_upd(1);
        check_fans(md);
        stop_test();
    end
endmodule // fan_tach_period_measure_tb
`default_nettype wire

//--- verification/ftp_fan_model.sv
// fan tachometer model: square wave per fan, pulled high while stopped
`timescale 1ns/1ps
`default_nettype none
module ftp_fan_model
    import ftp_pkg::*;
(
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    // per-fan run enable and half period in clocks
    input  wire logic [FAN_N-1:0] fan_run,
    input  wire logic [63:0]      half_cyc,
    // tach pins
    output logic      [FAN_N-1:0] fan_tach
);
    for (genvar i = 0; i < FAN_N; i++) begin : g_fan
        logic [15:0] cnt_r;
        logic        wave_r;
        always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
                cnt_r  <= 16'h0;
                wave_r <= 1'b1;
            end else if (!fan_run[i]) begin
                // open-collector output: pull-up wins while the fan is stopped
                cnt_r  <= 16'h0;
                wave_r <= 1'b1;
            end else if (cnt_r + 16'h1 >= half_cyc[16*i +: 16]) begin
                cnt_r  <= 16'h0;
                wave_r <= ~wave_r;
            end else begin
                cnt_r <= cnt_r + 16'h1;
            end
        end
        assign fan_tach[i] = wave_r;
    end
endmodule // ftp_fan_model
`default_nettype wire

//--- verification/ftp_monitor.sv
// assertion checker for the fan tach period block, bound to its top
`timescale 1ns/1ps
`default_nettype none
module ftp_monitor
    import ftp_pkg::*;
(
    // clock and reset
    input wire logic             core_clk,
    input wire logic             rst_n,
    // tach pins and mode
    input wire logic [FAN_N-1:0] fan_tach,
    input wire logic [7:0]       fan_acq_mode,
    // read port
    input wire logic             reg_rd_en,
    input wire logic [7:0]       reg_addr,
    input wire logic [7:0]       reg_rdata,
    input wire logic             reg_rd_valid,
    input wire logic             reg_hit,
    // status
    input wire logic [FAN_N-1:0] fan_updated,
    input wire logic [FAN_N-1:0] fan_stalled
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_valid_latency: assert property (reg_rd_en |=> reg_rd_valid)
        else $error("read answer missing one cycle after request");
    a_valid_cause: assert property (reg_rd_valid |-> $past(reg_rd_en))
        else $error("read answer without a request");
    a_hit_range: assert property (reg_rd_en |=>
        reg_hit == ($past(reg_addr) inside {[8'h6e:8'h75]}))
        else $error("register hit flag does not match address");
    a_unmapped_zero: assert property (reg_rd_valid && !reg_hit |-> reg_rdata == RD_UNMAPPED)
        else $error("unmapped read returned nonzero data");
    a_data_hold: assert property (!$past(reg_rd_en) |-> $stable(reg_rdata))
        else $error("read data changed without a read");
    a_state_legal: assert property (reg_rd_valid && reg_hit && !$past(reg_addr[0]) |->
        reg_rdata[1:0] != ACQ_RESERVED)
        else $error("reserved acquisition state reported");

    for (genvar i = 0; i < FAN_N; i++) begin : g_fan
        // cycles since the last stored result; one second is 20M clocks
        logic [24:0] idle_r;
        always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
                idle_r <= 25'h0;
            end else begin
                idle_r <= fan_updated[i] ? 25'h0 : idle_r + 25'h1;
            end
        end
        a_refresh_bound: assert property (idle_r < 25'h1312d00)
            else $error("fan count not refreshed within one second");
        a_stall_sync: assert property ($changed(fan_stalled[i]) |->
            fan_updated[i] || $past(fan_updated[i]))
            else $error("stall flag moved without a new result");
    end
endmodule // ftp_monitor

bind ftp_top ftp_monitor u_ftp_monitor (
    .core_clk(core_clk), .rst_n(rst_n), .fan_tach(fan_tach), .fan_acq_mode(fan_acq_mode),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid), .reg_hit(reg_hit), .fan_updated(fan_updated),
    .fan_stalled(fan_stalled)
);
`default_nettype wire
